// *** pkg/fbsp_cfg.svh ***
// Constants of the flow-through burst SRAM port: widths, lanes, strap levels.
// Assumes inclusion by bare name from package and modules.
`ifndef FBSP_CFG_SVH
`define FBSP_CFG_SVH
`define FBSP_ADDR_W 19
`define FBSP_DATA_W 32
`define FBSP_LANES 4
`define FBSP_LANE_W 8
`define FBSP_WORD_W 36
`define FBSP_PAR_POS 32
`define FBSP_OFFS_W 2
`define FBSP_ALL_LANES 4'hf
`define FBSP_NO_LANES 4'h0
`define FBSP_STRAP_LINEAR 1'b0
`define FBSP_SYNC_RST 2'h0
`endif

// *** pkg/fbsp_pkg.sv ***
// Types of the flow-through burst SRAM port.
// Assumes the constants header is on the include path.
`include "fbsp_cfg.svh"
package fbsp_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_BURST = 2'b01,
    ST_SLEEP = 2'b10
  } fbsp_state_type;
  typedef logic [`FBSP_LANES-1:0] fbsp_lanes_type;
  typedef logic [`FBSP_WORD_W-1:0] fbsp_word_type;
  typedef logic [`FBSP_OFFS_W-1:0] fbsp_offs_type;
endpackage : fbsp_pkg

// *** pkg/fbsp_burst_if.sv ***
// Link between the port logic and its 2-bit burst counter.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface fbsp_burst_if;
  import fbsp_pkg::*;
  logic load;
  logic step;
  logic interleave;
  fbsp_offs_type start;
  fbsp_offs_type cur_offs;
  fbsp_offs_type next_offs;
  modport ctl (output load, output step, output interleave, output start,
    input cur_offs, input next_offs);
  modport ctr (input load, input step, input interleave, input start,
    output cur_offs, output next_offs);
endinterface : fbsp_burst_if

// *** verilog/fbsp_burst_ctr.sv ***
// Wrapping 2-bit burst counter with linear or interleaved order.
// Assumes load and step come from logic on the same clock.
`timescale 1ns/1ps
module fbsp_burst_ctr
  import fbsp_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  fbsp_burst_if.ctr bif
);
  fbsp_offs_type base_q;
  fbsp_offs_type cnt_q;
  fbsp_offs_type cnt_inc;

  function automatic fbsp_offs_type fbsp_seq(input fbsp_offs_type b, input fbsp_offs_type c,
                                            input logic il);
    return il ? (b ^ c) : fbsp_offs_type'(b + c);
  endfunction : fbsp_seq

  assign cnt_inc = fbsp_offs_type'(cnt_q + 2'h1);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      base_q <= 2'h0;
      cnt_q <= 2'h0;
    end else if (bif.load) begin
      base_q <= bif.start;
      cnt_q <= 2'h0;
    end else if (bif.step) begin
      cnt_q <= cnt_inc;
    end
  end

  assign bif.cur_offs = fbsp_seq(base_q, cnt_q, bif.interleave);
  assign bif.next_offs = bif.step ? fbsp_seq(base_q, cnt_inc, bif.interleave) : bif.cur_offs;

  AST_HOLD: assert property (@(posedge clk) disable iff (!arst_n)
    !bif.load && !bif.step |=> $stable(cnt_q))
    else $error("burst counter moved without step");
endmodule : fbsp_burst_ctr

// *** verilog/fbsp_top.sv ***
// Flow-through burst SRAM port: strobes, selects, burst, byte writes, output drive.
// Assumes synchronous inputs come from logic on clk; strap and sleep are asynchronous.
// Contract
// - Capture address when a strobe is low and all three selects are active.
// - An accepted strobe loads the two low address bits into the counter.
// - Byte selects are active low and write only while the byte gate is low.
// - Global write low writes every lane, ignoring byte selects and gate.
// - Burst counter steps on each edge with burst advance low.
// - Selected only when first and third selects low and second high.
// - Processor strobe ignored while the first select is high.
// - With both strobes low, only the processor strobe acts.
// - Output enable low drives data lines; high floats them as inputs.
// - Output enable masked in first read cycle after a deselected state.
// - Strap low selects linear order, high selects interleaved order.
// - Sleep input high enters a low-activity state keeping memory contents.
// - Data and parity inputs are registered on the rising edge.
// - Driven data is the word addressed at the preceding edge.
// - Counter wraps in four; linear adds, interleaved XORs the start.
// - Data lines float whenever a write cycle is detected.
// - Processor-started access ignores write and advance in its first cycle.
`timescale 1ns/1ps
`include "fbsp_cfg.svh"
module fbsp_top
  import fbsp_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [`FBSP_ADDR_W-1:0] addr,
  input wire logic processor_addr_strobe_n,
  input wire logic controller_addr_strobe_n,
  input wire logic burst_advance_n,
  input wire logic byte_lane_select_0_n,
  input wire logic byte_lane_select_1_n,
  input wire logic byte_lane_select_2_n,
  input wire logic byte_lane_select_3_n,
  input wire logic global_write_n,
  input wire logic byte_write_gate_n,
  input wire logic chip_select_low_a_n,
  input wire logic chip_select_high,
  input wire logic chip_select_low_b_n,
  input wire logic output_enable_n,
  input wire logic burst_order_strap,
  input wire logic sleep_request,
  input wire logic [`FBSP_DATA_W-1:0] data_io_lines_i,
  output logic [`FBSP_DATA_W-1:0] data_io_lines_o,
  output logic data_io_lines_oe,
  input wire logic [`FBSP_LANES-1:0] parity_io_lines_i,
  output logic [`FBSP_LANES-1:0] parity_io_lines_o,
  output logic parity_io_lines_oe
);
  localparam int HI_W = `FBSP_ADDR_W - `FBSP_OFFS_W;

  fbsp_burst_if bif ();
  fbsp_state_type state_q;
  fbsp_state_type state_d;
  logic [1:0] sleep_sync_q;
  logic [1:0] mode_sync_q;
  logic [HI_W-1:0] addr_hi_q;
  logic drive_q;
  fbsp_word_type rd_q;
  fbsp_word_type rd_d;
  fbsp_word_type wr_word;
  fbsp_word_type mem [0:(1<<`FBSP_ADDR_W)-1];
  fbsp_lanes_type lane_sel;
  fbsp_lanes_type lanes_req;
  fbsp_lanes_type wr_lanes;
  logic [`FBSP_ADDR_W-1:0] wr_addr;
  logic [`FBSP_ADDR_W-1:0] rd_addr;
  logic sleep_s;
  logic active;
  logic selected;
  logic proc_strobe_eff;
  logic strobe;
  logic accept;
  logic deselect;

  fbsp_burst_ctr u_ctr (
    .clk(clk),
    .arst_n(arst_n),
    .bif(bif)
  );

  // Two-flop synchronisers for the asynchronous sleep input and order strap
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sleep_sync_q <= `FBSP_SYNC_RST;
      mode_sync_q <= `FBSP_SYNC_RST;
    end else begin
      sleep_sync_q <= {sleep_sync_q[0], sleep_request};
      mode_sync_q <= {mode_sync_q[0], burst_order_strap};
    end
  end

  assign sleep_s = sleep_sync_q[1];
  assign active = (state_q == ST_BURST);
  assign selected = !chip_select_low_a_n && chip_select_high && !chip_select_low_b_n;
  assign proc_strobe_eff = !processor_addr_strobe_n && !chip_select_low_a_n;
  assign strobe = proc_strobe_eff || !controller_addr_strobe_n;
  assign accept = strobe && selected && (state_q != ST_SLEEP) && !sleep_s;
  assign deselect = strobe && !selected;

  assign lane_sel = {byte_lane_select_3_n, byte_lane_select_2_n,
                     byte_lane_select_1_n, byte_lane_select_0_n};

  // Write lanes of this edge
  always_comb begin
    if (!global_write_n) begin
      lanes_req = `FBSP_ALL_LANES;
    end else if (!byte_write_gate_n) begin
      lanes_req = ~lane_sel;
    end else begin
      lanes_req = `FBSP_NO_LANES;
    end
    if (accept) begin
      wr_lanes = proc_strobe_eff ? `FBSP_NO_LANES : lanes_req;
      wr_addr = addr;
    end else if (active) begin
      wr_lanes = lanes_req;
      wr_addr = {addr_hi_q, bif.cur_offs};
    end else begin
      wr_lanes = `FBSP_NO_LANES;
      wr_addr = {addr_hi_q, bif.cur_offs};
    end
  end

  assign bif.load = accept;
  assign bif.start = addr[`FBSP_OFFS_W-1:0];
  assign bif.step = active && !accept && !burst_advance_n;
  assign bif.interleave = (mode_sync_q[1] != `FBSP_STRAP_LINEAR);

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (sleep_s) begin
          state_d = ST_SLEEP;
        end else if (accept) begin
          state_d = ST_BURST;
        end
      end
      ST_BURST: begin
        if (sleep_s) begin
          state_d = ST_SLEEP;
        end else if (deselect) begin
          state_d = ST_IDLE;
        end
      end
      ST_SLEEP: begin
        if (!sleep_s) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      addr_hi_q <= '0;
    end else if (accept) begin
      addr_hi_q <= addr[`FBSP_ADDR_W-1:`FBSP_OFFS_W];
    end
  end

  // Incoming lanes: data bytes plus one parity bit each
  always_comb begin
    wr_word = '0;
    for (int i = 0; i < `FBSP_LANES; i++) begin
      wr_word[i*`FBSP_LANE_W +: `FBSP_LANE_W] = data_io_lines_i[i*`FBSP_LANE_W +: `FBSP_LANE_W];
      wr_word[`FBSP_PAR_POS+i] = parity_io_lines_i[i];
    end
  end

  // Memory array: inputs registered at the edge; holds contents through sleep
  always_ff @(posedge clk) begin
    for (int i = 0; i < `FBSP_LANES; i++) begin
      if (wr_lanes[i]) begin
        mem[wr_addr][i*`FBSP_LANE_W +: `FBSP_LANE_W] <=
          wr_word[i*`FBSP_LANE_W +: `FBSP_LANE_W];
        mem[wr_addr][`FBSP_PAR_POS+i] <= wr_word[`FBSP_PAR_POS+i];
      end
    end
  end

  // Flow-through read of the address taken at this edge, with write bypass
  assign rd_addr = accept ? addr : {addr_hi_q, bif.next_offs};
  always_comb begin
    rd_d = mem[rd_addr];
    if (rd_addr == wr_addr) begin
      for (int i = 0; i < `FBSP_LANES; i++) begin
        if (wr_lanes[i]) begin
          rd_d[i*`FBSP_LANE_W +: `FBSP_LANE_W] = wr_word[i*`FBSP_LANE_W +: `FBSP_LANE_W];
          rd_d[`FBSP_PAR_POS+i] = wr_word[`FBSP_PAR_POS+i];
        end
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_q <= '0;
    end else begin
      rd_q <= rd_d;
    end
  end

  // Drive permission for the cycle after this edge
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      drive_q <= 1'b0;
    end else begin
      drive_q <= (state_d == ST_BURST) && (wr_lanes == `FBSP_NO_LANES)
                 && !(accept && !active);
    end
  end

  assign data_io_lines_oe = !output_enable_n && drive_q && active
                            && (lanes_req == `FBSP_NO_LANES);
  assign parity_io_lines_oe = data_io_lines_oe;
  assign data_io_lines_o = rd_q[`FBSP_DATA_W-1:0];
  assign parity_io_lines_o = rd_q[`FBSP_WORD_W-1:`FBSP_PAR_POS];

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence seq_sleep_held;
    sleep_request [*3];
  endsequence

  sequence seq_new_read;
    accept && (state_q == ST_IDLE);
  endsequence

  AST_LOAD: assert property (accept |=> (addr_hi_q == $past(addr[`FBSP_ADDR_W-1:2])) &&
    (bif.cur_offs == $past(addr[1:0])))
    else $error("accepted address not captured");
  AST_SEL: assert property (strobe && !selected && (state_q == ST_BURST) && !sleep_s
    |=> state_q == ST_IDLE)
    else $error("deselect did not end the access");
  AST_FIRST_SEL: assert property (!processor_addr_strobe_n && chip_select_low_a_n &&
    controller_addr_strobe_n && burst_advance_n && !sleep_s && (state_q != ST_SLEEP) |=>
    $stable(bif.cur_offs) && (state_q == $past(state_q)))
    else $error("processor strobe acted with first select high");
  AST_PWIN: assert property (accept && !processor_addr_strobe_n |->
    wr_lanes == `FBSP_NO_LANES)
    else $error("write taken on processor strobe edge");
  AST_GLOBAL: assert property (active && !accept && !global_write_n |->
    wr_lanes == `FBSP_ALL_LANES)
    else $error("global write missed a lane");
  AST_GATE: assert property (active && global_write_n && byte_write_gate_n |->
    wr_lanes == `FBSP_NO_LANES)
    else $error("byte write without gate");
  AST_LIN: assert property (bif.step && !bif.interleave && !accept |=>
    bif.cur_offs == fbsp_offs_type'($past(bif.cur_offs) + 2'h1))
    else $error("linear burst did not advance by one");
  AST_STAY: assert property (active && !accept && burst_advance_n |=>
    $stable(bif.cur_offs))
    else $error("burst address moved without advance");
  AST_TRI: assert property (lanes_req != `FBSP_NO_LANES |-> !data_io_lines_oe)
    else $error("data driven during write");
  AST_WR_AFTER: assert property (wr_lanes != `FBSP_NO_LANES |=> !data_io_lines_oe)
    else $error("data driven right after a write");
  AST_MASK: assert property (seq_new_read |=> !data_io_lines_oe)
    else $error("output enable not masked after deselect");
  AST_SLEEP: assert property (seq_sleep_held |=> state_q == ST_SLEEP)
    else $error("sleep not entered");
  AST_OEH: assert property (output_enable_n |-> !data_io_lines_oe)
    else $error("driving with output enable high");
endmodule : fbsp_top

// *** tb/fbsp_ctl_model.sv ***
// Controller model: drives the synchronous inputs of the SRAM port at the falling edge.
// Assumes one bench process calls its tasks, one bus cycle per call.
`timescale 1ns/1ps
`include "fbsp_cfg.svh"
module fbsp_ctl_model
  import fbsp_pkg::*;
(
  input wire logic clk,
  output logic [`FBSP_ADDR_W-1:0] addr,
  output logic processor_addr_strobe_n,
  output logic controller_addr_strobe_n,
  output logic chip_select_low_a_n,
  output logic chip_select_high,
  output logic chip_select_low_b_n,
  output logic burst_advance_n,
  output logic global_write_n,
  output logic byte_write_gate_n,
  output logic byte_lane_select_3_n,
  output logic byte_lane_select_2_n,
  output logic byte_lane_select_1_n,
  output logic byte_lane_select_0_n,
  output logic burst_order_strap,
  output logic [`FBSP_DATA_W-1:0] data_io_lines_i,
  output logic [`FBSP_LANES-1:0] parity_io_lines_i
);
  logic [11:0] ctl_bits = 12'hd7f;
  fbsp_word_type wdata = '0;
  logic [`FBSP_ADDR_W-1:0] addr_bits = '0;
  logic strap_bit = 1'b0;
  assign {processor_addr_strobe_n, controller_addr_strobe_n, chip_select_low_a_n,
    chip_select_high, chip_select_low_b_n, burst_advance_n, global_write_n,
    byte_write_gate_n, byte_lane_select_3_n, byte_lane_select_2_n,
    byte_lane_select_1_n, byte_lane_select_0_n} = ctl_bits;
  assign {parity_io_lines_i, data_io_lines_i} = wdata;
  assign addr = addr_bits;
  assign burst_order_strap = strap_bit;
  // One bus cycle; address and data carry junk when not qualified
  task automatic cyc(input logic [11:0] c, input logic [`FBSP_ADDR_W-1:0] a,
    input fbsp_word_type d);
    @(negedge clk);
    ctl_bits = c;
    addr_bits = (&c[11:10]) ? ~addr_bits : a;
    wdata = (c[5] && c[4]) ? ~wdata : d;
    @(posedge clk);
    #1;
  endtask : cyc
  // Strap moves only with the bus quiet, then settles
  task automatic mode(input logic m);
    @(negedge clk);
    strap_bit = m;
    repeat (3) @(posedge clk);
  endtask : mode
endmodule : fbsp_ctl_model

// *** tb/testbench.sv ***
// Self-checking bench of the flow-through burst SRAM port.
// Assumes the controller model owns the synchronous inputs.
`timescale 1ns/1ps
`include "fbsp_cfg.svh"
module testbench;
  import fbsp_pkg::*;
  localparam logic [`FBSP_ADDR_W-1:0] base = 19'h4_5670;
  localparam fbsp_word_type merged = 36'h7_12ff_56ff;
  localparam fbsp_word_type ones = 36'hf_ffff_ffff;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic output_enable_n = 1'b1;
  logic sleep_request = 1'b0;
  logic [`FBSP_ADDR_W-1:0] addr;
  logic processor_addr_strobe_n, controller_addr_strobe_n, chip_select_low_a_n;
  logic chip_select_high, chip_select_low_b_n, burst_advance_n, global_write_n;
  logic byte_write_gate_n, byte_lane_select_3_n, byte_lane_select_2_n;
  logic byte_lane_select_1_n, byte_lane_select_0_n, burst_order_strap;
  logic [`FBSP_DATA_W-1:0] data_io_lines_i, data_io_lines_o;
  logic [`FBSP_LANES-1:0] parity_io_lines_i, parity_io_lines_o;
  logic data_io_lines_oe, parity_io_lines_oe;
  wire fbsp_word_type q = {parity_io_lines_o, data_io_lines_o};
  wire [1:0] oe = {parity_io_lines_oe, data_io_lines_oe};
  int fail_count = 0;
  int comparisons = 0;
  int cycles = 0;
  // Strap, start offset, then the four offsets visited, first at the top
  logic [11:0] rows [8] = '{12'h01b, 12'h16c, 12'h2b1, 12'h3c6,
    12'h41b, 12'h54e, 12'h6b1, 12'h7e4};
  fbsp_top fbsp_top_i (.clk, .arst_n, .addr, .processor_addr_strobe_n,
    .controller_addr_strobe_n, .burst_advance_n, .byte_lane_select_0_n,
    .byte_lane_select_1_n, .byte_lane_select_2_n, .byte_lane_select_3_n,
    .global_write_n, .byte_write_gate_n, .chip_select_low_a_n, .chip_select_high,
    .chip_select_low_b_n, .output_enable_n, .burst_order_strap, .sleep_request,
    .data_io_lines_i, .data_io_lines_o, .data_io_lines_oe, .parity_io_lines_i,
    .parity_io_lines_o, .parity_io_lines_oe);
  fbsp_ctl_model fbsp_ctl_model_i (.clk, .addr, .processor_addr_strobe_n,
    .controller_addr_strobe_n, .chip_select_low_a_n, .chip_select_high,
    .chip_select_low_b_n, .burst_advance_n, .global_write_n, .byte_write_gate_n,
    .byte_lane_select_3_n, .byte_lane_select_2_n, .byte_lane_select_1_n,
    .byte_lane_select_0_n, .burst_order_strap, .data_io_lines_i, .parity_io_lines_i);
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      fail_count++;
      summarize();
    end
  end
  function automatic fbsp_word_type word(input logic [1:0] k);
    return {2'h0, k, 32'h1234_5670 + 32'(k)};
  endfunction : word
  task automatic chk(input fbsp_word_type seen, input fbsp_word_type exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic cy(input logic [11:0] c, input logic [`FBSP_ADDR_W-1:0] a,
    input fbsp_word_type d);
    fbsp_ctl_model_i.cyc(c, a, d);
  endtask : cy
  task automatic summarize;
    $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : summarize
  initial begin
    repeat (10) @(posedge clk);
    chk(oe, 2'h0);
    @(negedge clk);
    arst_n = 1'b1;
    output_enable_n = 1'b0;
    $display("Test reset done");
    for (int k = 0; k < 4; k++) begin
      cy(12'h95f, base + 19'(k), word(2'(k)));
    end
    foreach (rows[r]) begin
      cy(12'h87f, '0, '0);
      fbsp_ctl_model_i.mode(rows[r][10]);
      cy(12'h57f, base + 19'(rows[r][9:8]), '0);
      chk(oe, 2'h0);
      chk(q, word(rows[r][7:6]));
      for (int s = 1; s < 5; s++) begin
        cy(12'hd3f, '0, '0);
        chk(oe, 2'h3);
        chk(q, word(rows[r][7 - 2 * (s % 4) -: 2]));
      end
      cy(12'hd7f, '0, '0);
      chk(q, word(rows[r][7:6]));
      @(negedge clk);
      output_enable_n = 1'b1;
      #1 chk(oe, 2'h0);
      output_enable_n = 1'b0;
      $display("Test row %0d done", r);
    end
    cy(12'h77f, base + 19'h1, '0);
    chk(q, word(2'h3));
    chk(oe, 2'h3);
    cy(12'h15f, base + 19'h2, ones);
    chk(q, word(2'h2));
    chk(oe, 2'h0);
    cy(12'hd6a, '0, ones);
    chk(q, merged);
    chk(oe, 2'h0);
    cy(12'hd70, '0, '0);
    chk(q, merged);
    cy(12'hd0a, '0, ones);
    chk(q, word(2'h3));
    chk(oe, 2'h0);
    cy(12'h57f, base + 19'h2, '0);
    chk(q, ones);
    chk(oe, 2'h3);
    $display("Test strobes and writes done");
    cy(12'h87f, '0, '0);
    @(negedge clk);
    sleep_request = 1'b1;
    repeat (3) cy(12'h87f, '0, '0);
    cy(12'h57f, base + 19'h2, '0);
    cy(12'hd3f, '0, '0);
    chk(oe, 2'h0);
    @(negedge clk);
    sleep_request = 1'b0;
    repeat (3) cy(12'h87f, '0, '0);
    cy(12'h57f, base + 19'h2, '0);
    chk(q, ones);
    $display("Test sleep done");
    cy(12'h87f, '0, '0);
    @(negedge clk);
    arst_n = 1'b0;
    #1 chk(oe, 2'h0);
    chk(q, '0);
    repeat (2) @(posedge clk);
    @(negedge clk);
    arst_n = 1'b1;
    cy(12'h57f, base + 19'h2, '0);
    chk(oe, 2'h0);
    chk(q, ones);
    $display("Test mid-run reset done");
    summarize();
  end
endmodule : testbench
